// [hdl/scd_core.sv]
// datapath and register set of the 4-bit stack cpu core
// assumes an external sequencer issuing one micro-op per machine cycle and an
// external program memory answering progData combinationally for progAddr
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: 12-bit counter increments per linear instruction
// RULE2: branch, call, return, interrupt load counter
// RULE3: table op pushes 8-bit program constant
// RULE4: 4096-byte program space addressed by counter
// RULE5: low 512 bytes hold short call entries
// RULE6: 256x4 RAM reachable by four pointers
// RULE7: stack pointer preincrements push, postdecrements pop
// RULE8: pop copies second entry before decrement
// RULE9: software loads stack pointer before use
// RULE10: return entries 12-bit, pointer steps four
// RULE11: software sets return pointer to FCh
// RULE12: return stack holds returns, swaps with stack
// RULE13: index fetch pushes nibble, store writes top
// RULE14: index pointers preincrement or postdecrement
// RULE15: top register loads from ALU, memories, I/O
// RULE16: flag register with direct flag instructions
// RULE17: carry records carry, fifth shift bit
// RULE18: logic keeps carry, arithmetic updates it
// RULE19: conditional branch jumps on branch flag
// RULE20: reset and mask clear enable; enable sets
// RULE21: ALU works on top two entries
// RULE22: machine cycle spans two clocks
// RULE23: interrupt pushes counter, calls service vector
// RULE24: pointers cleared anyway, no overflow checks
module scd_core (
  // clock and reset
  input  wire  logic                   ref_clk,
  input  wire  logic                   sys_rst,
  // register bus
  input  wire  logic [3:0]             regAddr,
  input  wire  logic [11:0]            regWrData,
  input  wire  logic                   regWrStrobe,
  input  wire  logic                   regRdStrobe,
  output logic       [11:0]            regRdData,
  // micro-op port
  input  wire  logic                   opValid,
  input  wire  scd_pkg::scd_op_type    opCode,
  input  wire  logic [11:0]            opData,
  output logic                         opReady,
  // program memory
  output logic       [11:0]            progAddr,
  input  wire  logic [7:0]             progData,
  // peripheral i/o bus
  input  wire  logic [3:0]             ioRdData,
  output logic       [3:0]             ioWrData,
  output logic                         ioWrStrobe,
  // core state
  output logic       [3:0]             topOfStack,
  output logic       [3:0]             conditionFlags
);

  // ==================================================================
  // state
  logic [11:0] pcReg, pcNext;
  logic [7:0]  spReg, spNext, rpReg, rpNext, paReg, paNext, pbReg, pbNext;
  logic [3:0]  tosReg, tosNext, flagsReg, flagsNext;
  logic        phaseReg;
  logic [3:0]  ramMem [scd_pkg::RAM_DEPTH];
  logic [2:0]  wrEn;
  logic [7:0]  wrAddr [3];
  logic [3:0]  wrData [3];
  logic [3:0]  ioWrDataNext;
  logic        ioWrNext;

  logic        take;
  logic [3:0]  secondEntry;
  logic [11:0] rsTop, pcInc;
  logic [4:0]  aluRes;
  logic        carryIn, branchIn;
  logic [7:0]  ptrSel, ptrPre, ptrAddr;

  // one op per machine cycle: second clock of the cycle refuses new ops
  assign opReady = ~phaseReg; // RULE22
  assign take    = opValid & ~phaseReg;

  assign secondEntry = ramMem[spReg];
  assign rsTop   = {ramMem[rpReg - 8'h03], ramMem[rpReg - 8'h02], ramMem[rpReg - 8'h01]};
  assign pcInc   = pcReg + 12'h001;
  assign carryIn = flagsReg[scd_pkg::FLAG_CARRY];
  assign branchIn = flagsReg[scd_pkg::FLAG_BRANCH];
  assign ptrSel  = opData[2] ? pbReg : paReg;
  assign ptrPre  = ptrSel + 8'h01;
  assign ptrAddr = (opData[1:0] == scd_pkg::MODE_PREINC) ? ptrPre : ptrSel;

  // ==================================================================
  // alu on top two entries, carry is the fifth bit
  always_comb begin
    unique case (opCode)
      scd_pkg::OP_ADD:  aluRes = {1'b0, secondEntry} + {1'b0, tosReg}; // RULE21
      scd_pkg::OP_ADDC: aluRes = {1'b0, secondEntry} + {1'b0, tosReg} + {4'h0, carryIn};
      scd_pkg::OP_SUB:  aluRes = {1'b0, secondEntry} - {1'b0, tosReg};
      scd_pkg::OP_SUBB: aluRes = {1'b0, secondEntry} - {1'b0, tosReg} - {4'h0, carryIn};
      scd_pkg::OP_AND:  aluRes = {carryIn, secondEntry & tosReg};
      scd_pkg::OP_OR:   aluRes = {carryIn, secondEntry | tosReg};
      scd_pkg::OP_XOR:  aluRes = {carryIn, secondEntry ^ tosReg};
      scd_pkg::OP_NOT:  aluRes = {carryIn, ~tosReg};
      scd_pkg::OP_SHL:  aluRes = {tosReg, 1'b0}; // RULE17
      scd_pkg::OP_SHR:  aluRes = {tosReg[0], 1'b0, tosReg[3:1]};
      scd_pkg::OP_ROL:  aluRes = {tosReg, carryIn};
      scd_pkg::OP_ROR:  aluRes = {tosReg[0], carryIn, tosReg[3:1]};
      default:          aluRes = {carryIn, tosReg};
    endcase
  end

  // ==================================================================
  // next state of the datapath
  always_comb begin
    pcNext       = pcReg;
    spNext       = spReg;
    rpNext       = rpReg;
    paNext       = paReg;
    pbNext       = pbReg;
    tosNext      = tosReg;
    flagsNext    = flagsReg;
    wrEn         = 3'h0;
    ioWrNext     = 1'b0;
    ioWrDataNext = tosReg;
    for (int i = 0; i < 3; i++) begin
      wrAddr[i] = 8'h00;
      wrData[i] = 4'h0;
    end
    if (take) begin
      unique case (opCode)
        scd_pkg::OP_NOP: pcNext = pcInc; // RULE1
        scd_pkg::OP_LIT, scd_pkg::OP_IN: begin
          wrEn[0]   = 1'b1; // RULE7
          wrAddr[0] = spReg + 8'h01;
          wrData[0] = tosReg;
          spNext    = spReg + 8'h01;
          tosNext   = (opCode == scd_pkg::OP_IN) ? ioRdData : opData[3:0]; // RULE15
          pcNext    = pcInc;
        end
        scd_pkg::OP_TABLE: begin
          // the byte at the counter arrives as two nibbles, high one deeper
          wrEn      = 3'h3; // RULE3
          wrAddr[0] = spReg + 8'h01;
          wrData[0] = tosReg;
          wrAddr[1] = spReg + 8'h02;
          wrData[1] = progData[7:4];
          spNext    = spReg + 8'h02;
          tosNext   = progData[3:0];
          pcNext    = pcInc;
        end
        scd_pkg::OP_OUT, scd_pkg::OP_DROP, scd_pkg::OP_FLAGS_WRITE: begin
          tosNext  = secondEntry; // RULE8
          spNext   = spReg - 8'h01;
          ioWrNext = (opCode == scd_pkg::OP_OUT);
          if (opCode == scd_pkg::OP_FLAGS_WRITE) begin
            flagsNext = tosReg & scd_pkg::FLAGS_USED; // RULE16
          end
          pcNext = pcInc;
        end
        scd_pkg::OP_BRANCH: pcNext = opData; // RULE2
        scd_pkg::OP_COND_BRANCH: pcNext = branchIn ? opData : pcInc; // RULE19
        scd_pkg::OP_CALL, scd_pkg::OP_SHORT_CALL, scd_pkg::OP_INT_ACK: begin
          // a masked interrupt acknowledge leaves everything untouched
          if (opCode != scd_pkg::OP_INT_ACK || flagsReg[scd_pkg::FLAG_IE]) begin
            wrEn      = 3'h7; // RULE10
            wrAddr[0] = rpReg + 8'h01;
            wrAddr[1] = rpReg + 8'h02;
            wrAddr[2] = rpReg + 8'h03;
            {wrData[0], wrData[1], wrData[2]} =
              (opCode == scd_pkg::OP_INT_ACK) ? pcReg : pcInc; // RULE23
            rpNext = rpReg + 8'(scd_pkg::RS_STEP);
            pcNext = (opCode == scd_pkg::OP_CALL) ? opData : (opData & scd_pkg::ZP_MASK); // RULE5
          end
        end
        scd_pkg::OP_RETURN, scd_pkg::OP_RETI: begin
          pcNext = rsTop; // RULE12
          rpNext = rpReg - 8'(scd_pkg::RS_STEP);
        end
        scd_pkg::OP_TO_RSTACK: begin
          wrEn      = 3'h7;
          wrAddr[0] = rpReg + 8'h01;
          wrAddr[1] = rpReg + 8'h02;
          wrAddr[2] = rpReg + 8'h03;
          wrData[0] = ramMem[spReg - 8'h01];
          wrData[1] = secondEntry;
          wrData[2] = tosReg;
          rpNext    = rpReg + 8'(scd_pkg::RS_STEP);
          tosNext   = ramMem[spReg - 8'h02];
          spNext    = spReg - 8'h03;
          pcNext    = pcInc;
        end
        scd_pkg::OP_FROM_RSTACK: begin
          wrEn      = 3'h7; // RULE12
          wrAddr[0] = spReg + 8'h01;
          wrAddr[1] = spReg + 8'h02;
          wrAddr[2] = spReg + 8'h03;
          wrData[0] = tosReg;
          wrData[1] = rsTop[11:8];
          wrData[2] = rsTop[7:4];
          tosNext   = rsTop[3:0];
          spNext    = spReg + 8'h03;
          rpNext    = rpReg - 8'(scd_pkg::RS_STEP);
          pcNext    = pcInc;
        end
        scd_pkg::OP_FETCH: begin
          wrEn[0]   = 1'b1; // RULE13
          wrAddr[0] = spReg + 8'h01;
          wrData[0] = tosReg;
          spNext    = spReg + 8'h01;
          tosNext   = ramMem[ptrAddr]; // RULE6
          pcNext    = pcInc;
        end
        scd_pkg::OP_STORE: begin
          wrEn[0]   = 1'b1; // RULE13
          wrAddr[0] = ptrAddr;
          wrData[0] = tosReg;
          tosNext   = secondEntry;
          spNext    = spReg - 8'h01;
          pcNext    = pcInc;
        end
        scd_pkg::OP_ADD, scd_pkg::OP_ADDC, scd_pkg::OP_SUB, scd_pkg::OP_SUBB,
        scd_pkg::OP_AND, scd_pkg::OP_OR, scd_pkg::OP_XOR: begin
          tosNext = aluRes[3:0]; // RULE21
          spNext  = spReg - 8'h01;
          flagsNext[scd_pkg::FLAG_CARRY] = aluRes[4]; // RULE18
          flagsNext[scd_pkg::FLAG_BRANCH] =
            (opCode inside {scd_pkg::OP_AND, scd_pkg::OP_OR, scd_pkg::OP_XOR}) ?
            (aluRes[3:0] == 4'h0) : aluRes[4]; // RULE19
          pcNext = pcInc;
        end
        scd_pkg::OP_NOT, scd_pkg::OP_SHL, scd_pkg::OP_SHR, scd_pkg::OP_ROL,
        scd_pkg::OP_ROR: begin
          tosNext = aluRes[3:0];
          flagsNext[scd_pkg::FLAG_CARRY] = aluRes[4]; // RULE17
          flagsNext[scd_pkg::FLAG_BRANCH] =
            (opCode == scd_pkg::OP_NOT) ? (aluRes[3:0] == 4'h0) : aluRes[4];
          pcNext = pcInc;
        end
        scd_pkg::OP_SET_BRANCH_CARRY: begin
          flagsNext[scd_pkg::FLAG_CARRY]  = 1'b1; // RULE16
          flagsNext[scd_pkg::FLAG_BRANCH] = 1'b1;
          pcNext = pcInc;
        end
        scd_pkg::OP_TOGGLE_BRANCH: begin
          flagsNext[scd_pkg::FLAG_BRANCH] = ~branchIn;
          pcNext = pcInc;
        end
        scd_pkg::OP_MASK_INT: begin
          flagsNext[scd_pkg::FLAG_IE] = 1'b0; // RULE20
          pcNext = pcInc;
        end
        scd_pkg::OP_ENABLE_INT: begin
          flagsNext[scd_pkg::FLAG_IE] = 1'b1; // RULE20
          pcNext = pcInc;
        end
        default: pcNext = pcInc;
      endcase
      // index pointer side effects of the addressing mode
      if (opCode inside {scd_pkg::OP_FETCH, scd_pkg::OP_STORE} &&
          opData[1:0] != scd_pkg::MODE_PLAIN) begin
        if (opData[2]) begin
          pbNext = (opData[1:0] == scd_pkg::MODE_PREINC) ? ptrPre : pbReg - 8'h01; // RULE14
        end else begin
          paNext = (opData[1:0] == scd_pkg::MODE_PREINC) ? ptrPre : paReg - 8'h01;
        end
      end
    end else if (regWrStrobe) begin
      // software writes lose to an op taken in the same cycle
      unique case (regAddr)
        scd_pkg::OFS_PC:    pcNext = regWrData;
        scd_pkg::OFS_SP:    spNext = regWrData[7:0]; // RULE9
        scd_pkg::OFS_RP:    rpNext = regWrData[7:0]; // RULE11
        scd_pkg::OFS_PTRA:  paNext = regWrData[7:0];
        scd_pkg::OFS_PTRB:  pbNext = regWrData[7:0];
        scd_pkg::OFS_TOS:   tosNext = regWrData[3:0];
        scd_pkg::OFS_FLAGS: flagsNext = regWrData[3:0] & scd_pkg::FLAGS_USED;
        default: ;
      endcase
    end
  end

  // ==================================================================
  // registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseReg <= 1'b0;
    end else begin
      phaseReg <= take; // RULE22
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcReg    <= scd_pkg::PC_RST; // RULE4
      flagsReg <= scd_pkg::FLAGS_RST; // RULE20
      tosReg   <= scd_pkg::TOS_RST;
      // pointers are cleared only to keep simulation free of unknowns
      spReg    <= scd_pkg::PTR_RST; // RULE24
      rpReg    <= scd_pkg::PTR_RST;
      paReg    <= scd_pkg::PTR_RST;
      pbReg    <= scd_pkg::PTR_RST;
    end else begin
      pcReg    <= pcNext;
      flagsReg <= flagsNext;
      tosReg   <= tosNext;
      spReg    <= spNext;
      rpReg    <= rpNext;
      paReg    <= paNext;
      pbReg    <= pbNext;
    end
  end

  // ram has no reset; contents are undefined until software writes them
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (wrEn[i]) begin
        ramMem[wrAddr[i]] <= wrData[i]; // RULE6
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ioWrStrobe <= 1'b0;
      ioWrData   <= 4'h0;
    end else begin
      ioWrStrobe <= ioWrNext;
      ioWrData   <= ioWrDataNext;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 12'h000;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        scd_pkg::OFS_PC:    regRdData <= pcReg;
        scd_pkg::OFS_SP:    regRdData <= {4'h0, spReg};
        scd_pkg::OFS_RP:    regRdData <= {4'h0, rpReg};
        scd_pkg::OFS_PTRA:  regRdData <= {4'h0, paReg};
        scd_pkg::OFS_PTRB:  regRdData <= {4'h0, pbReg};
        scd_pkg::OFS_TOS:   regRdData <= {8'h00, tosReg};
        scd_pkg::OFS_FLAGS: regRdData <= {8'h00, flagsReg};
        scd_pkg::OFS_STAT:  regRdData <= {11'h000, phaseReg};
        default:            regRdData <= 12'h000;
      endcase
    end else begin
      regRdData <= 12'h000;
    end
  end

  assign progAddr       = pcReg;
  assign topOfStack     = tosReg;
  assign conditionFlags = flagsReg;

  // ==================================================================
  // checks
  pc_linear_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    take && opCode == scd_pkg::OP_NOP |=> pcReg == $past(pcReg) + 12'h001)
    else $error("counter did not step on linear op");
  pc_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    take && opCode == scd_pkg::OP_BRANCH |=> pcReg == $past(opData))
    else $error("branch target not loaded");
  cond_branch_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE19
    take && opCode == scd_pkg::OP_COND_BRANCH && !branchIn |=> pcReg == $past(pcReg) + 12'h001)
    else $error("conditional branch taken with branch flag clear");
  sp_push_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
    take && opCode == scd_pkg::OP_LIT |=> spReg == $past(spReg) + 8'h01 && secondEntry == $past(tosReg))
    else $error("push did not preincrement");
  pop_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
    take && opCode == scd_pkg::OP_DROP |=> tosReg == $past(secondEntry) && spReg == $past(spReg) - 8'h01)
    else $error("pop did not copy second entry");
  rp_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    take && opCode == scd_pkg::OP_CALL |=> rpReg == $past(rpReg) + 8'h04 && rsTop == $past(pcInc))
    else $error("call did not stack return address");
  logic_carry_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE18
    take && opCode == scd_pkg::OP_AND |=> $stable(flagsReg[scd_pkg::FLAG_CARRY]))
    else $error("logic op changed carry");
  mask_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE20
    take && opCode == scd_pkg::OP_MASK_INT |=> !flagsReg[scd_pkg::FLAG_IE])
    else $error("mask op left interrupts enabled");
  machine_cycle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE22
    take |=> !opReady ##1 opReady)
    else $error("machine cycle not two clocks");
  int_masked_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE23
    take && opCode == scd_pkg::OP_INT_ACK && !flagsReg[scd_pkg::FLAG_IE] |=> $stable(pcReg))
    else $error("masked interrupt changed counter");

endmodule // scd_core

`default_nettype wire

// [hdl/scd_pkg.sv]
// package for the stack cpu core datapath: widths, bus map, flag layout, micro-op codes
// assumes a single 25 MHz clock domain shared by every user of these names
package scd_pkg;

  // ==================================================================
  // widths and memory sizes
  localparam int PC_W        = 12;
  localparam int PTR_W       = 8;
  localparam int NIB_W       = 4;
  localparam int RAM_DEPTH   = 256;
  localparam int PROG_BYTES  = 4096;
  localparam int PROG_BLOCK  = 16;
  localparam int ZERO_PAGE   = 512;
  localparam int RS_STEP     = 4;
  localparam int CLK_PER_MC  = 2;

  // ==================================================================
  // register bus map, word offsets
  localparam logic [3:0] OFS_PC    = 4'h0;
  localparam logic [3:0] OFS_SP    = 4'h1;
  localparam logic [3:0] OFS_RP    = 4'h2;
  localparam logic [3:0] OFS_PTRA  = 4'h3;
  localparam logic [3:0] OFS_PTRB  = 4'h4;
  localparam logic [3:0] OFS_TOS   = 4'h5;
  localparam logic [3:0] OFS_FLAGS = 4'h6;
  localparam logic [3:0] OFS_STAT  = 4'h7;

  // ==================================================================
  // condition flag layout and reset values
  localparam int FLAG_IE     = 0;
  localparam int FLAG_BRANCH = 2;
  localparam int FLAG_CARRY  = 3;
  localparam logic [3:0]  FLAGS_USED  = 4'hd;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;
  localparam logic [11:0] PC_RST      = 12'h000;
  localparam logic [7:0]  PTR_RST     = 8'h00;
  localparam logic [3:0]  TOS_RST     = 4'h0;
  localparam logic [11:0] ZP_MASK     = 12'h1ff;

  // ==================================================================
  // fetch and store addressing modes (opData[1:0]) and pointer select (opData[2])
  localparam logic [1:0] MODE_PLAIN   = 2'h0;
  localparam logic [1:0] MODE_PREINC  = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP, OP_LIT, OP_TABLE, OP_IN, OP_OUT, OP_DROP,
    OP_BRANCH, OP_COND_BRANCH, OP_CALL, OP_SHORT_CALL, OP_RETURN, OP_RETI, OP_INT_ACK,
    OP_FETCH, OP_STORE, OP_TO_RSTACK, OP_FROM_RSTACK,
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR, OP_NOT,
    OP_SHL, OP_SHR, OP_ROL, OP_ROR,
    OP_SET_BRANCH_CARRY, OP_TOGGLE_BRANCH, OP_FLAGS_WRITE, OP_MASK_INT, OP_ENABLE_INT
  } scd_op_type;

endpackage

// [testbench/scd_far_side.sv]
// far-side model: program memory and peripheral port of the core
// assumes the core drives progAddr and its i/o write pins from ref_clk
`timescale 1ns/1ps
`default_nettype none
module scd_far_side (
  // clock
  input  wire logic        ref_clk,
  // program memory and i/o bus
  input  wire logic [11:0] progAddr,
  output logic      [7:0]  progData,
  input  wire logic [3:0]  ioWrData,
  input  wire logic        ioWrStrobe,
  output logic      [3:0]  ioRdData
);
  // ==========
  // memory and port
  logic [3:0] portLatch_reg;
  // rom content is an address hash, so a wrong address shows up
  assign progData = progAddr[7:0] ^ {progAddr[11:8], 4'h9};
  // port reads back the last write scrambled, never a plain echo
  assign ioRdData = portLatch_reg ^ 4'h5;
  always_ff @(posedge ref_clk) begin
    if (ioWrStrobe) begin
      portLatch_reg <= ioWrData;
    end
  end
endmodule // scd_far_side
`default_nettype wire

// [testbench/stack_cpu_core_datapath_bench.sv]
// self-checking bench for the stack cpu core datapath
// assumes scd_pkg, scd_core and scd_far_side are compiled first
`timescale 1ns/1ps
`default_nettype none
module stack_cpu_core_datapath_bench;
  // ==========
  // signals
  logic                ref_clk     = 1'b0;
  logic                sys_rst     = 1'b1;
  logic [3:0]          regAddr     = 4'h0;
  logic [11:0]         regWrData   = 12'h000;
  logic                regWrStrobe = 1'b0;
  logic                regRdStrobe = 1'b0;
  logic                opValid     = 1'b0;
  scd_pkg::scd_op_type opCode      = scd_pkg::OP_NOP;
  logic [11:0]         opData      = 12'h000;
  logic [11:0]         regRdData, progAddr;
  logic [7:0]          progData;
  logic [3:0]          ioRdData, ioWrData, topOfStack, conditionFlags;
  logic                opReady, ioWrStrobe;
  int                  num_errors  = 0;
  int                  checks      = 0;
  int                  cycles      = 0;

  scd_core dut_u (.ref_clk, .sys_rst, .regAddr, .regWrData, .regWrStrobe,
    .regRdStrobe, .regRdData, .opValid, .opCode, .opData, .opReady, .progAddr,
    .progData, .ioRdData, .ioWrData, .ioWrStrobe, .topOfStack, .conditionFlags);
  scd_far_side far_u (.ref_clk, .progAddr, .progData, .ioWrData, .ioWrStrobe,
    .ioRdData);

  always #20 ref_clk = ~ref_clk;
  // whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ==========
  // tasks
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [11:0] d);
    @(posedge ref_clk);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdChk(input logic [3:0] a, input logic [11:0] e);
    @(posedge ref_clk);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    check(regRdData, e);
  endtask
  task automatic doOp(input scd_pkg::scd_op_type c, input logic [11:0] d = 12'h000);
    int n;
    n = 0;
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= c;
    opData <= d;
    @(negedge ref_clk);
    while (opReady !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    opValid <= 1'b0;
    #1;
  endtask
  // returns carry, branch, result
  function automatic logic [5:0] aluRef(scd_pkg::scd_op_type c, logic [3:0] s,
                                        logic [3:0] t, logic ci);
    logic [4:0] r;
    logic       lg;
    lg = c inside {scd_pkg::OP_AND, scd_pkg::OP_OR, scd_pkg::OP_XOR, scd_pkg::OP_NOT};
    case (c)
      scd_pkg::OP_ADD:  r = s + t;
      scd_pkg::OP_ADDC: r = s + t + ci;
      scd_pkg::OP_SUB:  r = s - t;
      scd_pkg::OP_SUBB: r = s - t - ci;
      scd_pkg::OP_AND:  r = {ci, s & t};
      scd_pkg::OP_OR:   r = {ci, s | t};
      scd_pkg::OP_XOR:  r = {ci, s ^ t};
      scd_pkg::OP_NOT:  r = {ci, ~t};
      scd_pkg::OP_SHL:  r = {t, 1'b0};
      scd_pkg::OP_SHR:  r = {t[0], 1'b0, t[3:1]};
      scd_pkg::OP_ROL:  r = {t, ci};
      default:          r = {t[0], ci, t[3:1]};
    endcase
    return {r[4], lg ? (r[3:0] == 4'h0) : r[4], r[3:0]};
  endfunction
  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [3:0]          v [5];
    logic [3:0]          s, t;
    logic [5:0]          r;
    logic [7:0]          b;
    logic [11:0]         a;
    logic                cy;
    scd_pkg::scd_op_type c;
    void'($urandom(98));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdChk(4'(i), 12'h000);
    rdChk(4'hb, 12'h000);
    regWr(scd_pkg::OFS_SP, 12'h020);
    for (int i = 0; i < 5; i++) begin
      v[i] = 4'($urandom);
      doOp(scd_pkg::OP_LIT, {8'h00, v[i]});
      check(topOfStack, v[i]);
      rdChk(scd_pkg::OFS_SP, 12'h021 + 12'(i));
    end
    for (int i = 3; i >= 0; i--) begin
      doOp(scd_pkg::OP_DROP);
      check(topOfStack, v[i]);
      rdChk(scd_pkg::OFS_SP, 12'h021 + 12'(i));
    end
    rdChk(scd_pkg::OFS_PC, 12'h009);
    cy = 1'b0;
    for (int i = 0; i < 24; i++) begin
      s = (i == 0) ? 4'hf : 4'($urandom);
      t = (i == 0) ? 4'h1 : 4'($urandom);
      c = scd_pkg::scd_op_type'(6'(int'(scd_pkg::OP_ADD) + i % 12));
      doOp(scd_pkg::OP_LIT, {8'h00, s});
      doOp(scd_pkg::OP_LIT, {8'h00, t});
      doOp(c);
      r = aluRef(c, s, t, cy);
      cy = r[5];
      check(topOfStack, r[3:0]);
      check(conditionFlags, {r[5:4], 2'b00});
    end
    doOp(scd_pkg::OP_LIT, 12'h005);
    doOp(scd_pkg::OP_FLAGS_WRITE);
    check(conditionFlags, 4'h5);
    doOp(scd_pkg::OP_TOGGLE_BRANCH);
    check(conditionFlags, 4'h1);
    doOp(scd_pkg::OP_SET_BRANCH_CARRY);
    check(conditionFlags, 4'hd);
    doOp(scd_pkg::OP_MASK_INT);
    check(conditionFlags, 4'hc);
    regWr(scd_pkg::OFS_RP, 12'h0fc);
    regWr(scd_pkg::OFS_PC, 12'h5f0);
    doOp(scd_pkg::OP_CALL, 12'h9ab);
    rdChk(scd_pkg::OFS_PC, 12'h9ab);
    rdChk(scd_pkg::OFS_RP, 12'h000);
    doOp(scd_pkg::OP_RETURN);
    rdChk(scd_pkg::OFS_PC, 12'h5f1);
    rdChk(scd_pkg::OFS_RP, 12'h0fc);
    doOp(scd_pkg::OP_SHORT_CALL, 12'hfc3);
    rdChk(scd_pkg::OFS_PC, 12'h1c3);
    doOp(scd_pkg::OP_RETURN);
    doOp(scd_pkg::OP_INT_ACK, 12'h1e0);
    rdChk(scd_pkg::OFS_PC, 12'h5f2);
    doOp(scd_pkg::OP_ENABLE_INT);
    check(conditionFlags, 4'hd);
    doOp(scd_pkg::OP_INT_ACK, 12'h1e0);
    rdChk(scd_pkg::OFS_PC, 12'h1e0);
    doOp(scd_pkg::OP_RETI);
    rdChk(scd_pkg::OFS_PC, 12'h5f3);
    doOp(scd_pkg::OP_COND_BRANCH, 12'h2a0);
    rdChk(scd_pkg::OFS_PC, 12'h2a0);
    doOp(scd_pkg::OP_TOGGLE_BRANCH);
    doOp(scd_pkg::OP_COND_BRANCH, 12'h777);
    rdChk(scd_pkg::OFS_PC, 12'h2a2);
    regWr(scd_pkg::OFS_PC, 12'hfff);
    doOp(scd_pkg::OP_NOP);
    rdChk(scd_pkg::OFS_PC, 12'h000);
    for (int i = 0; i < 3; i++) begin
      a = 12'($urandom);
      b = a[7:0] ^ {a[11:8], 4'h9};
      regWr(scd_pkg::OFS_PC, a);
      doOp(scd_pkg::OP_TABLE);
      check(topOfStack, b[3:0]);
      doOp(scd_pkg::OP_DROP);
      check(topOfStack, b[7:4]);
    end
    regWr(scd_pkg::OFS_PTRA, 12'h080);
    for (int i = 0; i < 4; i++) begin
      v[i] = 4'($urandom);
      doOp(scd_pkg::OP_LIT, {8'h00, v[i]});
      doOp(scd_pkg::OP_STORE, 12'h001);
    end
    rdChk(scd_pkg::OFS_PTRA, 12'h084);
    for (int i = 3; i >= 0; i--) begin
      doOp(scd_pkg::OP_FETCH, 12'h002);
      check(topOfStack, v[i]);
    end
    rdChk(scd_pkg::OFS_PTRA, 12'h080);
    s = 4'($urandom);
    doOp(scd_pkg::OP_LIT, {8'h00, s});
    doOp(scd_pkg::OP_OUT);
    check(ioWrStrobe, 1'b1);
    check(ioWrData, s);
    doOp(scd_pkg::OP_IN);
    check(topOfStack, s ^ 4'h5);
    check(ioWrStrobe, 1'b0);
    for (int i = 0; i < 3; i++) begin
      v[i] = 4'($urandom);
      doOp(scd_pkg::OP_LIT, {8'h00, v[i]});
    end
    doOp(scd_pkg::OP_TO_RSTACK);
    rdChk(scd_pkg::OFS_RP, 12'h000);
    doOp(scd_pkg::OP_FROM_RSTACK);
    check(topOfStack, v[2]);
    doOp(scd_pkg::OP_DROP);
    check(topOfStack, v[1]);
    // a mid-run reset must drop the enable flag that software had set
    doOp(scd_pkg::OP_ENABLE_INT);
    check(conditionFlags, 4'h9);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdChk(scd_pkg::OFS_FLAGS, 12'h000);
    rdChk(scd_pkg::OFS_PC, 12'h000);
    conclude();
  end
endmodule // stack_cpu_core_datapath_bench
`default_nettype wire
